/* hw/mbs_broadcast_sender.sv */
// Behaviour
// RULE_01: When enabled, send the selected value on the link once every 250 ms cycle.
// RULE_02: Select setpoint, process value, output demand or error; anything else disables sending.
// RULE_03: Stop sending while another master talks; resume about 30 s after it falls silent.
// RULE_04: Receivers must use the same decimal resolution as this sender.
// RULE_05: Each value goes out as a 16-bit two's-complement integer.
// RULE_06: Values without fraction, including on/off codes, go out unchanged as integers.
// RULE_07: Fractional values go out times ten to the configured decimals; receivers divide back.
// RULE_08: Hours-resolution durations go out as hours times sixty plus minutes.
// RULE_09: Minutes-resolution durations go out as minutes times sixty plus seconds.
// RULE_10: Fractional values can also be read back as 32-bit IEEE single precision.
// RULE_11: Durations can also be read back as 32-bit total milliseconds.
// RULE_12: Each broadcast is a broadcast frame with function code 6, write single register.
// RULE_13: Any valid received request frame marks another master and restarts the quiet timer.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mbs_broadcast_sender #(
  parameter logic [32:0] CYCLE_CYCLES = mbs_pkg::MBS_CNT_W'(mbs_pkg::MBS_CYCLE_CYC),
  parameter logic [32:0] QUIET_CYCLES = mbs_pkg::MBS_CNT_W'(mbs_pkg::MBS_QUIET_CYC),
  parameter int FIFO_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_frame_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready
);
  import mbs_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    // pready and pslverr live for one cycle only; prdata holds until the next setup cycle.
    logic pready;
    logic pslverr;
    logic [31:0] prdata;

    // Settings and the four values that software may pick from.
    logic [2:0] sel;
    mbs_fmt_e fmt;
    logic [1:0] dp;
    logic [15:0] target;
    logic [31:0] wsp;
    logic [31:0] pv;
    logic [31:0] op;
    logic [31:0] err;

    // Timebase and the quiet period that follows a foreign master.
    logic [32:0] tick_cnt;
    logic [32:0] quiet_cnt;
    logic inhibit;

    // Frame under construction; word and address are frozen at the tick.
    mbs_state_e state;
    logic [2:0] idx;
    logic [15:0] word;
    logic [15:0] addr;
    logic [15:0] crc;
    logic [7:0] frames;

    // The link byte is registered so that it never changes while it is offered.
    logic [7:0] tx_data;
    logic tx_valid;
  } mbs_top_s;

  mbs_top_s st_ff;
  mbs_top_s nxt_st;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic sel_valid(input logic [2:0] s);
    sel_valid = (s == MBS_SEL_WORKING_SETPOINT_CHOICE) || (s == MBS_SEL_PROCESS_VALUE_CHOICE) ||
                (s == MBS_SEL_OUTPUT_DEMAND_CHOICE) || (s == MBS_SEL_ERROR_CHOICE);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ MBS_CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      MBS_OFS_CTRL, MBS_OFS_TARGET, MBS_OFS_WSP, MBS_OFS_PV, MBS_OFS_OP, MBS_OFS_ERR, MBS_OFS_STATUS,
      MBS_OFS_READ32: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // ************************************************************
  // Encoder and output FIFO
  // ************************************************************
  logic [31:0] sel_value;
  logic [15:0] enc_word;
  logic [31:0] enc_alt32;
  logic enabled;
  logic tick;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;

  always_comb begin
    case (st_ff.sel)
      MBS_SEL_WORKING_SETPOINT_CHOICE: begin
        sel_value = st_ff.wsp; // RULE_02
      end
      MBS_SEL_PROCESS_VALUE_CHOICE: begin
        sel_value = st_ff.pv;
      end
      MBS_SEL_OUTPUT_DEMAND_CHOICE: begin
        sel_value = st_ff.op;
      end
      MBS_SEL_ERROR_CHOICE: begin
        sel_value = st_ff.err;
      end
      default: begin
        sel_value = 32'h0000_0000;
      end
    endcase
  end

  mbs_value_encoder u_enc (
    .value(sel_value),
    .fmt(st_ff.fmt),
    .dp(st_ff.dp),
    .word(enc_word),
    .alt32(enc_alt32)
  );

  assign enabled = sel_valid(st_ff.sel) && !st_ff.inhibit; // RULE_02 RULE_03
  assign tick = st_ff.tick_cnt == CYCLE_CYCLES - 33'h0_0000_0001;

  // The byte order is fixed by the frame layout: broadcast address, function, register, value, CRC.
  always_comb begin
    case (st_ff.idx)
      3'h0: begin
        fifo_in_data = MBS_BCAST_ADDR; // RULE_12
      end
      3'h1: begin
        fifo_in_data = MBS_FC_WRITE_SINGLE; // RULE_12
      end
      3'h2: begin
        fifo_in_data = st_ff.addr[15:8];
      end
      3'h3: begin
        fifo_in_data = st_ff.addr[7:0];
      end
      3'h4: begin
        fifo_in_data = st_ff.word[15:8]; // RULE_05
      end
      3'h5: begin
        fifo_in_data = st_ff.word[7:0];
      end
      3'h6: begin
        fifo_in_data = st_ff.crc[7:0];
      end
      default: begin
        fifo_in_data = st_ff.crc[15:8];
      end
    endcase
  end

  assign fifo_in_valid = st_ff.state == MBS_ST_SEND;
  assign fifo_out_ready = !st_ff.tx_valid || tx_ready;

  mbs_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;

    // ************************************************************
    // Register bus
    // ************************************************************
    // APB: zero wait states; the answer is prepared in the setup cycle.
    nxt_st.pready = psel && !penable;
    nxt_st.pslverr = psel && !penable && !addr_mapped(paddr);
    if (psel && !penable) begin
      case (paddr)
        MBS_OFS_CTRL: begin
          nxt_st.prdata = {24'h00_0000, st_ff.dp, st_ff.fmt, 1'b0, st_ff.sel};
        end
        MBS_OFS_TARGET: begin
          nxt_st.prdata = {16'h0000, st_ff.target};
        end
        MBS_OFS_WSP: begin
          nxt_st.prdata = st_ff.wsp;
        end
        MBS_OFS_PV: begin
          nxt_st.prdata = st_ff.pv;
        end
        MBS_OFS_OP: begin
          nxt_st.prdata = st_ff.op;
        end
        MBS_OFS_ERR: begin
          nxt_st.prdata = st_ff.err;
        end
        MBS_OFS_STATUS: begin
          nxt_st.prdata = {st_ff.word, st_ff.frames, 6'h00, st_ff.inhibit, enabled};
        end
        MBS_OFS_READ32: begin
          nxt_st.prdata = enc_alt32; // RULE_10 RULE_11
        end
        default: begin
          nxt_st.prdata = 32'h0000_0000;
        end
      endcase
    end
    if (psel && penable && st_ff.pready && pwrite) begin
      case (paddr)
        MBS_OFS_CTRL: begin
          nxt_st.sel = pwdata[MBS_CTRL_SEL_LSB +: 3];
          nxt_st.fmt = mbs_fmt_e'(pwdata[MBS_CTRL_FMT_LSB +: 2]);
          nxt_st.dp = pwdata[MBS_CTRL_DP_LSB +: 2];
        end
        MBS_OFS_TARGET: begin
          nxt_st.target = pwdata[15:0];
        end
        MBS_OFS_WSP: begin
          nxt_st.wsp = pwdata;
        end
        MBS_OFS_PV: begin
          nxt_st.pv = pwdata;
        end
        MBS_OFS_OP: begin
          nxt_st.op = pwdata;
        end
        MBS_OFS_ERR: begin
          nxt_st.err = pwdata;
        end
        default: begin
          nxt_st.target = st_ff.target;
        end
      endcase
    end

    // ************************************************************
    // Timebase and quiet period
    // ************************************************************
    // Control-cycle timebase, free running.
    nxt_st.tick_cnt = tick ? 33'h0_0000_0000 : st_ff.tick_cnt + 33'h0_0000_0001; // RULE_01

    // A foreign request restarts the quiet period; it wins over the period running out.
    if (rx_frame_valid) begin
      nxt_st.inhibit = 1'b1; // RULE_13
      nxt_st.quiet_cnt = 33'h0_0000_0000; // RULE_13
    end else if (st_ff.inhibit) begin
      if (st_ff.quiet_cnt == QUIET_CYCLES - 33'h0_0000_0001) begin
        nxt_st.inhibit = 1'b0; // RULE_03
        nxt_st.quiet_cnt = 33'h0_0000_0000;
      end else begin
        nxt_st.quiet_cnt = st_ff.quiet_cnt + 33'h0_0000_0001;
      end
    end

    // ************************************************************
    // Frame builder
    // ************************************************************
    // A frame already under way is finished; a tick that finds the sender busy is skipped
    // rather than queued, so a stalled link never builds a backlog of stale values.
    case (st_ff.state)
      MBS_ST_IDLE: begin
        if (tick && enabled) begin
          nxt_st.word = enc_word; // RULE_01
          nxt_st.addr = st_ff.target;
          nxt_st.crc = MBS_CRC_INIT;
          nxt_st.idx = 3'h0;
          nxt_st.state = MBS_ST_SEND;
        end
      end
      MBS_ST_SEND: begin
        if (fifo_in_ready) begin
          if (st_ff.idx < MBS_CRC_LO_IDX) begin
            nxt_st.crc = crc_byte(st_ff.crc, fifo_in_data);
          end
          if (st_ff.idx == MBS_FRAME_LAST) begin
            nxt_st.state = MBS_ST_IDLE;
            nxt_st.frames = st_ff.frames + 8'h01;
          end else begin
            nxt_st.idx = st_ff.idx + 3'h1;
          end
        end
      end
      default: nxt_st.state = MBS_ST_IDLE;
    endcase

    // ************************************************************
    // Output stage
    // ************************************************************
    // Output stage keeps every link output on a flip-flop.
    if (fifo_out_valid && fifo_out_ready) begin
      nxt_st.tx_data = fifo_out_data;
      nxt_st.tx_valid = 1'b1;
    end else if (tx_ready) begin
      nxt_st.tx_valid = 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.sel <= MBS_CTRL_RST[2:0];
      st_ff.fmt <= MBS_FMT_INT;
      st_ff.target <= MBS_TARGET_RST;
      st_ff.wsp <= MBS_VALUE_RST;
      st_ff.pv <= MBS_VALUE_RST;
      st_ff.op <= MBS_VALUE_RST;
      st_ff.err <= MBS_VALUE_RST;
      st_ff.state <= MBS_ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign tx_data = st_ff.tx_data;
  assign tx_valid = st_ff.tx_valid;
endmodule
`default_nettype wire

/* hw/mbs_pkg.sv */
package mbs_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam longint unsigned MBS_CLK_PERIOD_PS = 5000;
  localparam longint unsigned MBS_CYCLE_MS = 250;
  localparam longint unsigned MBS_QUIET_S = 30;
  localparam longint unsigned MBS_CYCLE_CYC = (MBS_CYCLE_MS * 1000000000) / MBS_CLK_PERIOD_PS;
  localparam longint unsigned MBS_QUIET_CYC = (MBS_QUIET_S * 64'h0000_00E8_D4A5_1000) / MBS_CLK_PERIOD_PS;
  localparam int MBS_CNT_W = 33;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] MBS_OFS_CTRL = 8'h00;
  localparam logic [7:0] MBS_OFS_TARGET = 8'h04;
  localparam logic [7:0] MBS_OFS_WSP = 8'h08;
  localparam logic [7:0] MBS_OFS_PV = 8'h0C;
  localparam logic [7:0] MBS_OFS_OP = 8'h10;
  localparam logic [7:0] MBS_OFS_ERR = 8'h14;
  localparam logic [7:0] MBS_OFS_STATUS = 8'h18;
  localparam logic [7:0] MBS_OFS_READ32 = 8'h1C;

  localparam int MBS_CTRL_SEL_LSB = 0;
  localparam int MBS_CTRL_FMT_LSB = 4;
  localparam int MBS_CTRL_DP_LSB = 6;
  localparam int MBS_ST_ACTIVE_BIT = 0;
  localparam int MBS_ST_INHIBIT_BIT = 1;
  localparam int MBS_ST_COUNT_LSB = 8;
  localparam int MBS_ST_WORD_LSB = 16;

  localparam logic [7:0] MBS_CTRL_RST = 8'h00;
  localparam logic [15:0] MBS_TARGET_RST = 16'h0000;
  localparam logic [31:0] MBS_VALUE_RST = 32'h0000_0000;

  // ************************************************************
  // Frame constants
  // ************************************************************
  localparam logic [7:0] MBS_BCAST_ADDR = 8'h00;
  localparam logic [7:0] MBS_FC_WRITE_SINGLE = 8'h06;
  localparam logic [15:0] MBS_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] MBS_CRC_POLY = 16'hA001;
  localparam logic [2:0] MBS_FRAME_LAST = 3'h7;
  localparam logic [2:0] MBS_CRC_LO_IDX = 3'h6;

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [2:0] {
    MBS_SEL_NONE = 3'b000,
    MBS_SEL_WORKING_SETPOINT_CHOICE = 3'b001,
    MBS_SEL_PROCESS_VALUE_CHOICE = 3'b010,
    MBS_SEL_OUTPUT_DEMAND_CHOICE = 3'b011,
    MBS_SEL_ERROR_CHOICE = 3'b100
  } mbs_sel_e;

  typedef enum logic [1:0] {
    MBS_FMT_INT = 2'b00,
    MBS_FMT_SCALED = 2'b01,
    MBS_FMT_TIME_HOURS = 2'b10,
    MBS_FMT_TIME_MINUTES = 2'b11
  } mbs_fmt_e;

  typedef enum logic [1:0] {
    MBS_ST_IDLE = 2'b00,
    MBS_ST_SEND = 2'b01
  } mbs_state_e;

endpackage

/* hw/mbs_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module mbs_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } mbs_fifo_s;

  mbs_fifo_s st_ff;
  mbs_fifo_s nxt_st;
  logic push;
  logic pop;

  assign in_ready = st_ff.cnt != (AW+1)'(D);
  assign out_valid = st_ff.cnt != '0;
  assign out_data = st_ff.mem[st_ff.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_data;
      nxt_st.wr = (st_ff.wr == AW'(D - 1)) ? '0 : st_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd = (st_ff.rd == AW'(D - 1)) ? '0 : st_ff.rd + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

/* hw/mbs_value_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
module mbs_value_encoder (
  input wire logic [31:0] value,
  input wire mbs_pkg::mbs_fmt_e fmt,
  input wire logic [1:0] dp,
  output logic [15:0] word,
  output logic [31:0] alt32
);
  import mbs_pkg::*;

  // 0.001 as a 24-bit mantissa: 0x83126F * 2^-33.
  localparam logic [23:0] MILLI_MANT = 24'h83126F;
  localparam int MILLI_SHIFT = 33;

  // Truncates rather than rounds; the last mantissa bit may differ from a library conversion.
  function automatic logic [31:0] milli_to_float(input logic [31:0] v);
    logic [31:0] mag;
    logic [55:0] prod;
    int pos;
    logic [55:0] norm;
    mag = v[31] ? 32'(-v) : v;
    prod = 56'(mag) * 56'(MILLI_MANT);
    pos = 0;
    for (int i = 0; i < 56; i++) begin
      if (prod[i]) begin
        pos = i;
      end
    end
    norm = prod << (55 - pos);
    if (mag == 32'h0000_0000) begin
      milli_to_float = 32'h0000_0000;
    end else begin
      milli_to_float = {v[31], 8'(pos - MILLI_SHIFT + 127), norm[54:32]};
    end
  endfunction

  logic signed [31:0] scaled;
  logic [15:0] major;
  logic [15:0] minor;
  logic [31:0] total;

  always_comb begin
    major = {8'h00, value[15:8]};
    minor = {8'h00, value[7:0]};
    total = 32'(major) * 32'h0000_003C + 32'(minor);
    case (dp)
      2'b00: scaled = $signed(value) / 32'sh0000_03E8;
      2'b01: scaled = $signed(value) / 32'sh0000_0064;
      2'b10: scaled = $signed(value) / 32'sh0000_000A;
      default: scaled = $signed(value);
    endcase
    case (fmt)
      MBS_FMT_SCALED: begin
        if (scaled > 32'sh0000_7FFF) begin // RULE_07
          word = 16'h7FFF;
        end else if (scaled < -32'sh0000_8000) begin
          word = 16'h8000;
        end else begin
          word = scaled[15:0]; // RULE_05 RULE_07
        end
        alt32 = milli_to_float(value); // RULE_10
      end
      MBS_FMT_TIME_HOURS: begin
        word = total[15:0]; // RULE_08
        alt32 = 32'(total * 32'h0000_EA60); // RULE_11
      end
      MBS_FMT_TIME_MINUTES: begin
        word = total[15:0]; // RULE_09
        alt32 = 32'(total * 32'h0000_03E8); // RULE_11
      end
      default: begin
        word = value[15:0]; // RULE_06
        alt32 = value;
      end
    endcase
  end
endmodule
`default_nettype wire

/* dv/mbs_broadcast_sender_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module mbs_broadcast_sender_asserts #(
  parameter logic [32:0] QUIET_CYCLES = 33'h0_0000_03E8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_frame_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  import mbs_pkg::*;
  logic [2:0] idx_ff;
  logic [15:0] quiet_ff;
  // Quiet counter saturates; with the full-length quiet time only its first part is watched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_ff <= 3'h0;
      quiet_ff <= 16'hFFFF;
    end else begin
      if (tx_valid && tx_ready) idx_ff <= idx_ff + 3'h1;
      if (rx_frame_valid) quiet_ff <= 16'h0000;
      else if (quiet_ff != 16'hFFFF) quiet_ff <= quiet_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_FRAME_ADDR: assert property (tx_valid && idx_ff == 3'h0 |-> tx_data == 8'h00)
    else $error("frame does not open with the broadcast address");
  AST_FRAME_FUNC: assert property (tx_valid && idx_ff == 3'h1 |-> tx_data == 8'h06)
    else $error("frame does not carry the single write function");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("offered byte dropped or changed before it was taken");
  AST_QUIET_HOLD: assert property ($rose(tx_valid) && idx_ff == 3'h0 |->
    quiet_ff < 16'h0040 || {17'h0, quiet_ff} + 33'h8 >= QUIET_CYCLES)
    else $error("frame started while another master was active");
  AST_RESTART: assert property (rx_frame_valid |-> ##6 (!($rose(tx_valid) && idx_ff == 3'h0))[*8])
    else $error("frame started right after a received request");
  AST_APB_READY: assert property (psel && !penable |=> pready && psel && penable)
    else $error("register access not answered in the access cycle");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("register answer held longer than one cycle");
  AST_APB_ERR: assert property (psel && !penable && paddr > 8'h1C |=> pslverr)
    else $error("unmapped register access not refused");
  AST_APB_OK: assert property (psel && !penable && paddr <= 8'h1C && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped register access refused");
  cover property (tx_valid && tx_ready && idx_ff == 3'h7);
  cover property (rx_frame_valid);
  cover property (pslverr);
endmodule
bind mbs_broadcast_sender mbs_broadcast_sender_asserts #(.QUIET_CYCLES(QUIET_CYCLES)) mbs_broadcast_sender_asserts_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_frame_valid(rx_frame_valid),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
`default_nettype wire

/* dv/mbs_uart_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module mbs_uart_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] bytes[$];
  int starts[$];
  int cyc;
  logic prev_v;
  logic [2:0] idx;
  // Slow mode takes one byte in four cycles so the sender's FIFO backs up.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      idx <= 3'h0;
      prev_v <= 1'b0;
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      prev_v <= tx_valid;
      if (tx_valid && !prev_v && idx == 3'h0) starts.push_back(cyc);
      if (tx_valid && tx_ready) begin
        bytes.push_back(tx_data);
        idx <= idx + 3'h1;
      end
      tx_ready <= slow ? (cyc % 4 == 3) : 1'b1;
    end
  end
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mbs_pkg::*;
  localparam int CYC = 200;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_frame_valid, tx_valid, tx_ready, slow, e;
  logic [7:0] paddr, tx_data;
  logic [31:0] pwdata, prdata, rd;
  int errors, tests_run, n;
  logic [7:0] t_ctl[6] = '{8'h01, 8'h52, 8'h93, 8'h54, 8'h22, 8'h32};
  logic [31:0] t_val[6] = '{32'hFFFF_FFF7, 32'h0001_E26C, 32'h0000_2706, 32'hFFFF_FC18, 32'h0000_0203, 32'h0000_0C09};
  logic [15:0] t_word[6] = '{16'hFFF7, 16'h04D3, 16'h03E7, 16'hFFF6, 16'h007B, 16'h02D9};
  logic [31:0] t_r32[6] = '{32'hFFFF_FFF7, 32'h42F7_0000, 32'h411F_D70A, 32'hBF80_0000, 32'h0070_9C20, 32'h000B_1FA8};
  mbs_broadcast_sender #(.CYCLE_CYCLES(33'h0_0000_00C8), .QUIET_CYCLES(33'h0_0000_03E8), .FIFO_DEPTH(8))
    mbs_broadcast_sender_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_valid(rx_frame_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  mbs_uart_sink mbs_uart_sink_inst (.clk(pclk), .rst_n(presetn), .slow(slow), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0 ] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      k++;
      @(posedge pclk);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb wait states", 32'h0, k);
    @(posedge pclk);
  endtask
  function automatic logic [15:0] crc16(input logic [47:0] m);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 5; i >= 0; i--) begin
      c = c ^ {8'h00, m[i*8 +: 8]};
      for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  // Skips a frame that may mix old and new settings, then checks the next one whole.
  task automatic frame(input logic [15:0] tgt, input logic [15:0] w);
    int b, k;
    logic [63:0] f;
    logic [15:0] c;
    k = 0;
    b = ((mbs_uart_sink_inst.bytes.size() + 7) / 8) * 8 + 8;
    f[63:16] = {8'h00, 8'h06, tgt, w};
    c = crc16(f[63:16]);
    f[15:0] = {c[7:0], c[15:8]};
    while (mbs_uart_sink_inst.bytes.size() < b + 8 && k < 1000) begin
      k++;
      @(posedge pclk);
    end
    for (int i = 0; i < 8; i++) chk("frame byte", {24'h0, f[63-8*i -: 8]}, {24'h0, mbs_uart_sink_inst.bytes[b+i]});
  endtask
  task automatic pulse_rx();
    rx_frame_valid <= 1'b1;
    @(posedge pclk);
    rx_frame_valid <= 1'b0;
  endtask
  // ************************************************************
  // Stimulus
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("ERROR watchdog expected finish seen hang");
    complete_run();
  end
  initial begin
    errors = 0;
    tests_run = 0;
    {presetn, psel, penable, pwrite, rx_frame_valid, slow} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 8'h1C; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    repeat (3 * CYC) @(posedge pclk);
    chk("idle bytes", 32'h0, mbs_uart_sink_inst.bytes.size());
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      apb(1'b1, {3'h0, t_ctl[i][2:0], 2'h0} + 8'h04, t_val[i]);
      apb(1'b1, 8'h04, {16'h0, 8'hA5, i[7:0]});
      apb(1'b1, 8'h00, {24'h0, t_ctl[i]});
      frame({8'hA5, i[7:0]}, t_word[i]);
      apb(1'b0, 8'h1C, 32'h0);
      chk("read32", t_r32[i], rd);
    end
    n = mbs_uart_sink_inst.starts.size();
    chk("period", CYC, mbs_uart_sink_inst.starts[n-1] - mbs_uart_sink_inst.starts[n-2]);
    apb(1'b0, 8'h18, 32'h0);
    chk("status", {t_word[5], 16'h0001}, {rd[31:16], 15'h0, rd[0]});
    apb(1'b1, 8'h00, 32'h0);
    repeat (64) @(posedge pclk);
    n = mbs_uart_sink_inst.bytes.size();
    repeat (2 * CYC) @(posedge pclk);
    chk("none bytes", n, mbs_uart_sink_inst.bytes.size());
    apb(1'b1, 8'h00, 32'h0000_0001);
    repeat (CYC) @(posedge pclk);
    pulse_rx();
    repeat (64) @(posedge pclk);
    n = mbs_uart_sink_inst.bytes.size();
    apb(1'b0, 8'h18, 32'h0);
    chk("inhibit", 32'h1, {31'h0, rd[1]});
    repeat (900) @(posedge pclk);
    pulse_rx();
    repeat (900) @(posedge pclk);
    chk("inhibited bytes", n, mbs_uart_sink_inst.bytes.size());
    repeat (400) @(posedge pclk);
    chk("resumed", 32'h1, {31'h0, mbs_uart_sink_inst.bytes.size() > n});
    apb(1'b0, 8'h18, 32'h0);
    chk("inhibit cleared", 32'h0, {31'h0, rd[1]});
    complete_run();
  end
endmodule
`default_nettype wire
